// file: hw/wacq_top.sv
/*
 * Waveform acquisition control: turns a sample/trigger stream into
 * 2500-point records (1250 in peak) in sample, peak or average mode, with run/halt,
 * single sequence and roll display. APB slave for controls.
 * Assumes one 50 MHz clock ref_clk, samples synchronous to it, and
 * a record memory that accepts one point write per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wacq_cfg.svh"

// What this block does
// - Sample mode builds records of 2500 points shown at current timebase.
// - Sample mode stores one point per acquisition interval.
// - Reset selects sample mode.
// - At 100 ns/div or faster, interpolate between real samples to fill record.
// - Peak mode keeps high and low value in each of 1250 intervals.
// - At 2.5 ms/div or faster, peak mode falls back to sample; STATUS bit 3 then reads 0.
// - Average mode acquires as sample, then averages successive records.
// - Average count is 4, 16, 64 or 128.
// - Run/halt press starts continuous acquisition; next press stops it.
// - Single waits for trigger, completes acquisition, then halts.
// - Each single press arms another acquisition, even after completion.
// - In sample or peak mode a single ends after one record.
// - In average mode a single ends after the selected record count.
// - Roll mode when timebase 100 ms/div or slower and trigger free-running.
// - Roll writes new points from left edge toward right.
// - Roll computes a gap address one division ahead of new points; no point is written blank.
// - Triggered trigger mode leaves roll mode.
// - Halt freezes record; scale and position remain free downstream.
module wacq_top (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rstn,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Sample stream
	input  wire logic                    samp_valid,
	input  wire logic [`WACQ_SAMP_W-1:0] samp_data,
	input  wire logic                    trig_in,
	// Record output
	output wacq_pkg::wacq_point_t        pt_out,
	output logic                         pt_we,
	output logic                         rec_done,
	output logic                         roll_active,
	output logic                         acq_running
);

	// ****************************************************************
	// Register bus
	// ****************************************************************
	logic [31:0]          ctrl;
	logic [31:0]          next_prdata;
	logic                 wr_en;
	logic                 run_press;
	logic                 single_press;
	logic [7:0]           rec_count;
	wacq_pkg::wacq_mode_t sel_mode;
	wacq_pkg::wacq_mode_t eff_mode;
	wacq_pkg::wacq_avg_t  avg_sel;
	logic [4:0]           tb;
	logic                 free_run;
	logic                 interp;
	logic [7:0]           avg_target;
	logic [2:0]           avg_shift;

	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;

	// Decode used only for the pslverr response on reads and writes
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == `WACQ_OFS_CTRL) || (a == `WACQ_OFS_CMD) ||
			(a == `WACQ_OFS_STATUS) || (a == `WACQ_OFS_COUNT);
	endfunction

	assign pslverr = psel && penable && !mapped(paddr);

	// Control register; reset value gives sample mode
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctrl <= `WACQ_CTRL_RESET;
		end else if (wr_en && paddr == `WACQ_OFS_CTRL) begin
			ctrl <= pwdata & 32'h0000_03FF;
		end
	end

	// Command presses are one-cycle pulses from CMD writes
	assign run_press    = wr_en && paddr == `WACQ_OFS_CMD &&
		pwdata[`WACQ_CMD_RUN_BIT];
	assign single_press = wr_en && paddr == `WACQ_OFS_CMD &&
		pwdata[`WACQ_CMD_SINGLE_BIT];

	// Read mux; unmapped reads return zero with pslverr
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (paddr == `WACQ_OFS_CTRL) begin
			next_prdata = ctrl;
		end else if (paddr == `WACQ_OFS_STATUS) begin
			next_prdata = {28'h000_0000, eff_mode == wacq_pkg::WACQ_PEAK,
				roll_active, rec_done, acq_running};
		end else if (paddr == `WACQ_OFS_COUNT) begin
			next_prdata = {24'h00_0000, rec_count};
		end
	end
	assign prdata = next_prdata;

	// ****************************************************************
	// Mode resolution
	// ****************************************************************

	assign sel_mode = (ctrl[1:0] == 2'd3) ? wacq_pkg::WACQ_SAMPLE :
		wacq_pkg::wacq_mode_t'(ctrl[1:0]);
	assign avg_sel  = wacq_pkg::wacq_avg_t'(ctrl[3:2]);
	assign tb       = ctrl[8:4];
	assign free_run = ctrl[`WACQ_CTRL_FREE_BIT];

	// Peak fallback: STATUS bit 3 reads 1 only while peak is in effect
	assign eff_mode = (sel_mode == wacq_pkg::WACQ_PEAK &&
		tb <= `WACQ_TB_2P5MS) ? wacq_pkg::WACQ_SAMPLE : sel_mode;
	assign interp      = tb <= `WACQ_TB_100NS;
	assign roll_active = tb >= `WACQ_TB_100MS && free_run;

	// Only powers of two, so averaging is a shift
	always_comb begin
		case (avg_sel)
			wacq_pkg::WACQ_AVG4:  begin avg_target = 8'd4;   avg_shift = 3'd2; end
			wacq_pkg::WACQ_AVG16: begin avg_target = 8'd16;  avg_shift = 3'd4; end
			wacq_pkg::WACQ_AVG64: begin avg_target = 8'd64;  avg_shift = 3'd6; end
			default:              begin avg_target = 8'd128; avg_shift = 3'd7; end
		endcase
	end

	// ****************************************************************
	// Run / single sequencer
	// ****************************************************************
	wacq_pkg::wacq_state_t state;
	logic                  single_mode;
	logic                  rec_end;
	logic                  avg_clear;
	logic [3:0]            cfg_q;

	// Mode or count change restarts averaging
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cfg_q <= 4'h0;
		end else begin
			cfg_q <= {eff_mode, avg_sel};
		end
	end
	assign avg_clear = cfg_q != {eff_mode, avg_sel} || single_press;

	// Roll runs untriggered; otherwise each record waits for a trigger
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state       <= wacq_pkg::WACQ_HALT;
			single_mode <= 1'b0;
		end else if (single_press) begin
			state       <= wacq_pkg::WACQ_ARMED;
			single_mode <= 1'b1;
		end else if (run_press) begin
			single_mode <= 1'b0;
			state <= (state == wacq_pkg::WACQ_HALT) ? wacq_pkg::WACQ_ARMED :
				wacq_pkg::WACQ_HALT;
		end else begin
			case (state)
				wacq_pkg::WACQ_ARMED: begin
					if (trig_in || roll_active) begin
						state <= wacq_pkg::WACQ_CAPTURE;
					end
				end
				wacq_pkg::WACQ_CAPTURE: begin
					if (rec_end) begin
						// Single ends after one record, or N in average
						if (single_mode && (eff_mode != wacq_pkg::WACQ_AVERAGE ||
							rec_count + 8'd1 >= avg_target)) begin
							state <= wacq_pkg::WACQ_HALT;
						end else begin
							state <= roll_active ? wacq_pkg::WACQ_CAPTURE :
								wacq_pkg::WACQ_ARMED;
						end
					end
				end
				default: state <= wacq_pkg::WACQ_HALT;
			endcase
		end
	end
	assign acq_running = state != wacq_pkg::WACQ_HALT;

	// ****************************************************************
	// Record builder
	// ****************************************************************
	logic [11:0]             pos;
	logic                    half;
	logic [`WACQ_SAMP_W-1:0] prev;
	logic [`WACQ_SAMP_W-1:0] pk_hi;
	logic [`WACQ_SAMP_W-1:0] pk_lo;
	logic                    take;
	logic                    step;
	logic [`WACQ_SAMP_W:0]   mid;
	logic [11:0]             last_pos;
	logic                    wr_pt;

	// Halted means no writes, so the stored record stays frozen
	assign take = state == wacq_pkg::WACQ_CAPTURE && samp_valid;
	// Fast timebase: each real sample yields one point, alternately the midpoint with the previous sample or itself
	assign step = take;
	assign mid  = {1'b0, prev} + {1'b0, samp_data};
	assign last_pos = (eff_mode == wacq_pkg::WACQ_PEAK) ?
		`WACQ_PK_INTERVALS - 12'd1 : `WACQ_REC_POINTS - 12'd1;
	assign rec_end = step && (pos == last_pos) &&
		((eff_mode == wacq_pkg::WACQ_PEAK) ? half : (!interp || half));
	// Peak writes once per pair, so no interval spans two records
	assign wr_pt = take && (eff_mode != wacq_pkg::WACQ_PEAK || half);

	// Position walks left to right across the record
	always_ff @(posedge ref_clk) begin
		if (!rstn || state != wacq_pkg::WACQ_CAPTURE) begin
			pos  <= 12'h000;
			half <= 1'b0;
		end else if (step) begin
			if (rec_end) begin
				pos  <= 12'h000;
				half <= 1'b0;
			end else if (eff_mode == wacq_pkg::WACQ_PEAK) begin
				// Two samples per peak interval; advance after the second
				pos  <= half ? pos + 12'd1 : pos;
				half <= !half;
			end else if (interp) begin
				pos  <= pos + 12'd1;
				half <= !half;
			end else begin
				pos  <= pos + 12'd1;
				half <= 1'b0;
			end
		end
	end

	// Previous sample for interpolation; peak extrema per interval
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			prev  <= 8'h00;
			pk_hi <= 8'h00;
			pk_lo <= 8'hFF;
		end else if (take) begin
			prev  <= samp_data;
			pk_hi <= samp_data;
			pk_lo <= samp_data;
		end
	end

	// ****************************************************************
	// Averaging accumulator
	// ****************************************************************
	logic [`WACQ_ACC_W-1:0]  acc_mem [0:2499];
	logic [`WACQ_ACC_W-1:0]  acc_sum;
	logic [`WACQ_ACC_W-1:0]  acc_rd;
	logic [`WACQ_SAMP_W-1:0] pt_val;
	logic [`WACQ_ACC_W-1:0]  avg_val;

	assign pt_val  = (interp && !half) ? mid[`WACQ_SAMP_W:1] : samp_data;
	assign acc_rd  = (rec_count == 8'd0) ? 15'h0000 : acc_mem[pos];
	assign acc_sum = acc_rd + {7'h00, pt_val};
	assign avg_val = acc_sum >> avg_shift;

	// Per-point sums; count of records held since last restart
	always_ff @(posedge ref_clk) begin
		if (take && eff_mode == wacq_pkg::WACQ_AVERAGE) begin
			acc_mem[pos] <= (rec_count >= avg_target) ?
				acc_sum - (acc_rd >> avg_shift) : acc_sum;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn || avg_clear) begin
			rec_count <= 8'h00;
		end else if (rec_end && rec_count < avg_target) begin
			rec_count <= rec_count + 8'd1;
		end
	end

	// ****************************************************************
	// Point output
	// ****************************************************************
	// One point per interval; peak writes both extrema
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pt_out   <= '0;
			pt_we    <= 1'b0;
			rec_done <= 1'b0;
		end else begin
			pt_we    <= wr_pt;
			rec_done <= rec_end;
			if (wr_pt) begin
				pt_out.addr  <= pos;
				pt_out.blank <= 1'b0;
				if (eff_mode == wacq_pkg::WACQ_PEAK) begin
					pt_out.hi <= (samp_data > pk_hi) ? samp_data : pk_hi;
					pt_out.lo <= (samp_data < pk_lo) ? samp_data : pk_lo;
				end else if (eff_mode == wacq_pkg::WACQ_AVERAGE &&
					rec_count >= avg_target) begin
					pt_out.hi <= avg_val[`WACQ_SAMP_W-1:0];
					pt_out.lo <= avg_val[`WACQ_SAMP_W-1:0];
				end else begin
					pt_out.hi <= pt_val;
					pt_out.lo <= pt_val;
				end
			end
		end
	end

	// ****************************************************************
	// Roll gap: address a division ahead of the write point
	// ****************************************************************
	logic [11:0] gap_raw;
	logic [11:0] gap_pos;
	logic        gap_we;

	// Gap address wraps at 2500 points; in peak it runs past the 1250-point record end
	assign gap_raw = pos + `WACQ_DIV_POINTS;
	assign gap_pos = (gap_raw >= `WACQ_REC_POINTS) ?
		gap_raw - `WACQ_REC_POINTS : gap_raw;
	assign gap_we  = roll_active && take;

	// Gap address is held in blank_addr only; pt_out.blank stays 0
	logic [11:0] blank_addr;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			blank_addr <= 12'h000;
		end else if (gap_we) begin
			blank_addr <= gap_pos;
		end
	end

endmodule

`default_nettype wire

// file: inc/wacq_cfg.svh
/*
 * Constants of the waveform acquisition control: APB offsets, field
 * positions, reset values and record geometry.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef WACQ_CFG_SVH
`define WACQ_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define WACQ_OFS_CTRL      12'h000
`define WACQ_OFS_CMD       12'h004
`define WACQ_OFS_STATUS    12'h008
`define WACQ_OFS_COUNT     12'h00C

// ****************************************************************
// Field positions
// ****************************************************************
`define WACQ_CTRL_MODE_LO  0
`define WACQ_CTRL_AVG_LO   2
`define WACQ_CTRL_TB_LO    4
`define WACQ_CTRL_FREE_BIT 9
`define WACQ_CMD_RUN_BIT   0
`define WACQ_CMD_SINGLE_BIT 1

// ****************************************************************
// Reset values and geometry
// ****************************************************************
`define WACQ_CTRL_RESET    32'h0000_0000
`define WACQ_REC_POINTS    12'd2500
`define WACQ_PK_INTERVALS  12'd1250
`define WACQ_DIV_POINTS    12'd250
`define WACQ_SAMP_W        8
`define WACQ_ACC_W         15

// Timebase codes: ascending index means slower s/div
`define WACQ_TB_100NS      5'd6
`define WACQ_TB_2P5MS      5'd15
`define WACQ_TB_100MS      5'd20

`endif

// file: inc/wacq_pkg.sv
/*
 * Types of the waveform acquisition control.
 * Assumes wacq_cfg.svh on the include path.
 */
`include "wacq_cfg.svh"

package wacq_pkg;

	typedef enum logic [1:0] {
		WACQ_SAMPLE,
		WACQ_PEAK,
		WACQ_AVERAGE
	} wacq_mode_t;

	typedef enum logic [1:0] {
		WACQ_AVG4,
		WACQ_AVG16,
		WACQ_AVG64,
		WACQ_AVG128
	} wacq_avg_t;

	typedef enum {
		WACQ_HALT,
		WACQ_ARMED,
		WACQ_CAPTURE
	} wacq_state_t;

	// One record point toward memory/display
	typedef struct packed {
		logic [11:0]             addr;
		logic [`WACQ_SAMP_W-1:0] hi;
		logic [`WACQ_SAMP_W-1:0] lo;
		logic                    blank;
	} wacq_point_t;

endpackage

// file: verification/wacq_monitor.sv
/* Port checker for wacq_top.
   Assumes the bind below and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module wacq_monitor (
	// Clock and reset
	input wire logic                  ref_clk,
	input wire logic                  rstn,
	// Register bus
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [11:0]           paddr,
	input wire logic [31:0]           pwdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	// Record side
	input wire wacq_pkg::wacq_point_t pt_out,
	input wire logic                  pt_we,
	input wire logic                  rec_done,
	input wire logic                  roll_active,
	input wire logic                  acq_running
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic acc;
	logic wr_ctrl;
	logic wr_cmd;
	// Decoded bus accesses
	assign acc = psel && penable;
	assign wr_ctrl = acc && pwrite && paddr == 12'h000;
	assign wr_cmd = acc && pwrite && paddr == 12'h004;
	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_rst; disable iff (1'b0)
		!rstn |=> !pt_we && !rec_done && !acq_running; endproperty
	a_rst: assert property (p_rst)
		else $error("output active after reset");
	property p_err; acc && paddr > 12'h00C |-> pready && pslverr; endproperty
	a_err: assert property (p_err)
		else $error("unmapped access not refused");
	property p_roll; wr_ctrl && pwdata[9] && pwdata[8:4] >= 5'd20
		|=> roll_active; endproperty
	a_roll: assert property (p_roll)
		else $error("roll not entered");
	property p_trg; wr_ctrl && !pwdata[9] |=> !roll_active; endproperty
	a_trg: assert property (p_trg)
		else $error("roll kept in triggered mode");
	property p_run; wr_cmd && pwdata[1:0] == 2'b01 && !acq_running
		|=> acq_running; endproperty
	a_run: assert property (p_run)
		else $error("run press ignored");
	property p_stop; wr_cmd && pwdata[1:0] == 2'b01 && acq_running
		|=> !acq_running; endproperty
	a_stop: assert property (p_stop)
		else $error("stop press ignored");
	// Registered outputs trail the state by one cycle
	property p_halt; !acq_running && !$past(acq_running)
		&& !$past(acq_running, 2) |-> !pt_we; endproperty
	a_halt: assert property (p_halt)
		else $error("point written while halted");
	property p_addr; pt_we |-> pt_out.addr < 12'd2500; endproperty
	a_addr: assert property (p_addr)
		else $error("point address beyond record");
	property p_seq; pt_we && $past(pt_we) |-> pt_out.addr == 12'd0
		|| pt_out.addr == $past(pt_out.addr) + 12'd1; endproperty
	a_seq: assert property (p_seq)
		else $error("points not written left to right");
	property p_done; rec_done |=> !rec_done; endproperty
	a_done: assert property (p_done)
		else $error("record done longer than a pulse");
endmodule
bind wacq_top wacq_monitor u_mon (.ref_clk, .rstn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .pt_out, .pt_we,
	.rec_done, .roll_active, .acq_running);
`default_nettype wire

// file: verification/wacq_src.sv
/* Sample and trigger source standing in for the input channel.
   Assumes the bench drives en, clr and trig_req at rising edges. */
`timescale 1ns/1ps
`default_nettype none
`include "wacq_cfg.svh"
module wacq_src (
	// Clock and controls
	input wire logic                    ref_clk,
	input wire logic                    en,
	input wire logic                    clr,
	input wire logic                    trig_req,
	// Stream into the block
	output logic                        samp_valid,
	output logic [`WACQ_SAMP_W-1:0]     samp_data,
	output logic                        trig_in
);
	logic [`WACQ_SAMP_W-1:0] ramp;
	initial begin
		samp_valid = 1'b0;
		samp_data = '0;
		trig_in = 1'b0;
		ramp = '0;
	end
	// Ramp while enabled; idle data toggles so a stale value is never read
	always @(posedge ref_clk) begin
		samp_valid <= en;
		trig_in <= trig_req;
		ramp <= clr ? '0 : ramp + en;
		samp_data <= en ? ramp : ~samp_data;
	end
endmodule
`default_nettype wire

// file: verification/waveform_acquisition_control_test.sv
/* Self-checking bench for wacq_top over APB and the sample stream.
   Assumes wacq_src as stream source and wacq_monitor bound. */
`timescale 1ns/1ps
`default_nettype none
module waveform_acquisition_control_test;
	logic                  ref_clk, rstn, psel, penable, pwrite, err;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, rd;
	logic                  pready, pslverr, samp_valid, trig_in;
	logic                  pt_we, rec_done, roll_active, acq_running;
	logic                  en, clr, trig_req;
	logic [7:0]            samp_data, hi0, lo0;
	wacq_pkg::wacq_point_t pt_out;
	int                    n_errors, tests_run, n_pts, n_done, cyc;
	wacq_top uut (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .samp_valid, .samp_data,
		.trig_in, .pt_out, .pt_we, .rec_done, .roll_active, .acq_running);
	wacq_src src (.ref_clk, .en, .clr, .trig_req, .samp_valid,
		.samp_data, .trig_in);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Point tally and hang guard; the ceiling is about two and a half times the run
	always @(posedge ref_clk) begin
		if (pt_we && n_pts == 0) begin
			hi0 = pt_out.hi;
			lo0 = pt_out.lo;
		end
		n_pts += pt_we;
		n_done += rec_done;
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			end_sim;
		end
	end
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request holds until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Single sequence under a given setup, counting points and records
	task automatic cap(input logic [31:0] ctrl, input int recs);
		apb(1'b1, 12'h000, ctrl);
		n_pts = 0;
		n_done = 0;
		apb(1'b1, 12'h004, 32'h0000_0002);
		@(posedge ref_clk);
		trig_req <= 1'b1;
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		// Each averaged record waits for its own trigger
		while (n_done < recs) @(posedge ref_clk);
		trig_req <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk({31'h0, acq_running}, 32'h0000_0000);
		$display("capture %h done", ctrl);
	endtask
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		{en, trig_req} = '0;
		clr = 1'b1;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		en <= 1'b1;
		clr <= 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		$display("reset and bus done");
		cap(32'h0000_00A0, 1);
		chk(n_pts, 2500);
		cap(32'h0000_00A0, 1);
		chk(n_pts, 2500);
		cap(32'h0000_0101, 1);
		chk(n_pts, 1250);
		chk({16'h0000, hi0, lo0}, 32'h0000_0100);
		cap(32'h0000_00A1, 1);
		chk(n_pts, 2500);
		cap(32'h0000_0060, 1);
		chk(n_pts, 2500);
		cap(32'h0000_00A2, 4);
		chk(n_done, 4);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h0000_0004);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, 32'h0000_00A2 | (i << 2));
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, 32'h0000_00A2 | (i << 2));
		end
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b1, 12'h000, 32'h0000_0340);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd & 32'h0000_0004, 32'h0000_0004);
		apb(1'b1, 12'h000, 32'h0000_0140);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd & 32'h0000_0004, 32'h0000_0000);
		$display("roll done");
		trig_req <= 1'b1;
		apb(1'b1, 12'h004, 32'h0000_0001);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd & 32'h0000_0001, 32'h0000_0001);
		apb(1'b1, 12'h004, 32'h0000_0001);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd & 32'h0000_0001, 32'h0000_0000);
		trig_req <= 1'b0;
		repeat (3) @(posedge ref_clk);
		n_pts = 0;
		repeat (50) @(posedge ref_clk);
		chk(n_pts, 0);
		$display("run and halt done");
		end_sim;
	end
endmodule
`default_nettype wire
